// *** logic/ctr_consts.vh ***
`ifndef CTR_CONSTS_VH
`define CTR_CONSTS_VH

// ****************************************
// Command codes of the result registers
// ****************************************
`define CTR_CMD_CH1_CURR     8'h30
`define CTR_CMD_CH1_VOLT     8'h32
`define CTR_CMD_CH2_CURR     8'h34
`define CTR_CMD_CH2_VOLT     8'h36
`define CTR_CMD_CH3_CURR     8'h38
`define CTR_CMD_CH3_VOLT     8'h3A

// ****************************************
// Field layout and reset values
// ****************************************
`define CTR_RES_W            14
`define CTR_RES_RESET        14'h0000
`define CTR_LO_MSB           7
`define CTR_HI_MSB           13
`define CTR_HI_LSB           8

// ****************************************
// Current scaling: steps in nanoamperes per count, full scale and limit in milliamperes
// ****************************************
`define CTR_PORT_STEP_NA     89500
`define CTR_CLASS_STEP_NA    8950
`define CTR_CLASS_FINE_X     10
`define CTR_FULL_SCALE_MA    1460
`define CTR_CHAN_LIMIT_MA    1250
`define CTR_LIMIT_MULT       2

// ****************************************
// Timing
// ****************************************
`define CTR_CLK_HZ           25000000
`define CTR_REFRESH_MS       100
`define CTR_REFRESH_CYC      ((`CTR_CLK_HZ / 1000) * `CTR_REFRESH_MS)
// Last count of the refresh divider, sized to the 22-bit counter (period minus one)
`define CTR_REFRESH_LAST     22'h26259F

`endif

// *** logic/ctr_channel.v ***
`timescale 1ns/1ps
`include "ctr_consts.vh"

// ****************************************
// One channel: current and voltage result holding
// ****************************************
module ctr_channel (
    input  wire        mclk,          // System clock
    input  wire        resetn,        // Async reset, active low
    input  wire        refresh_en,    // One-cycle refresh tick
    input  wire        powered,       // Port is powered
    input  wire        port_enabled,  // Port is enabled
    input  wire        class_done,    // Classification measurement finished
    input  wire [13:0] class_count,   // Class current conversion
    input  wire        curr_done,     // Port current conversion finished
    input  wire [13:0] curr_count,    // Port current conversion
    input  wire        volt_done,     // Voltage conversion finished
    input  wire [13:0] volt_count,    // Voltage conversion
    output reg  [13:0] curr_result,   // Current result register
    output reg  [13:0] volt_result,   // Voltage result register
    output reg         class_scale,   // Result holds a class reading
    output reg         overcurrent    // Foldback disable request
);

    reg        curr_pend_q;           // Port reading waiting for refresh tick
    reg [13:0] curr_hold_q;           // Latest port reading
    wire [15:0] limit_cnt;

    // Limit threshold in port-current counts
    assign limit_cnt = 16'h3652; // ~ 1.25 A / 89.5 uA, inside the 14-bit full scale

    // Result update; class reading held until the refresh tick releases a port reading, or port off
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            curr_result <= `CTR_RES_RESET;
            volt_result <= `CTR_RES_RESET;
            class_scale <= 1'b0;
            curr_pend_q <= 1'b0;
            curr_hold_q <= `CTR_RES_RESET;
            overcurrent <= 1'b0;
        end else begin
            if (!port_enabled) begin
                curr_result <= `CTR_RES_RESET;
                class_scale <= 1'b0;
                curr_pend_q <= 1'b0;
            end else if (class_done) begin
                curr_result <= class_count;
                class_scale <= 1'b1;
            end else if (powered && curr_pend_q && refresh_en) begin
                curr_result <= curr_hold_q;
                class_scale <= 1'b0;
                curr_pend_q <= 1'b0;
            end
            // Capture the latest port reading; pace release at the tick
            if (port_enabled && powered && curr_done) begin
                curr_hold_q <= curr_count;
                curr_pend_q <= 1'b1;
            end
            if (volt_done && powered)
                volt_result <= volt_count;
            // Full scale saturates at 1.46 A; the limit trips above limit_cnt, about 1.25 A, below it
            overcurrent <= powered && curr_done &&
                           ({2'b00, curr_count} > limit_cnt);
        end
    end

endmodule // ctr_channel

// *** logic/ctr_readout.v ***
`timescale 1ns/1ps
`include "ctr_consts.vh"


// ****************************************
// Telemetry readout: three channels behind a command byte port
// ****************************************
module ctr_readout (
    input  wire        mclk,            // System clock, 25 MHz
    input  wire        resetn,          // Async reset, active low
    input  wire        cmd_valid,       // Command byte strobe
    input  wire [7:0]  cmd_code,        // Command code
    input  wire        rd_req,          // Data byte read request
    output reg  [7:0]  rd_data,         // Read byte
    output reg         rd_valid,        // Read byte valid, one cycle
    output reg         rd_err,          // Unmapped command read
    input  wire [2:0]  powered,         // Per channel powered
    input  wire [2:0]  port_enabled,    // Per channel enabled
    input  wire [2:0]  class_done,      // Per channel class finished
    input  wire [41:0] class_count,     // Class counts, ch1 low
    input  wire [2:0]  curr_done,       // Per channel current done
    input  wire [41:0] curr_count,      // Current counts, ch1 low
    input  wire [2:0]  volt_done,       // Per channel voltage done
    input  wire [41:0] volt_count,      // Voltage counts, ch1 low
    output wire [2:0]  class_scale,     // Result holds class reading
    output reg  [2:0]  fold_disable     // Foldback disable per channel
);

    // ****************************************
    // Refresh divider
    // ****************************************
    reg  [21:0] div_q;          // Refresh period counter
    wire        tick;           // One-cycle refresh enable
    wire [2:0]  oc;             // Per channel overcurrent request

    // Per channel count inputs
    wire [13:0] ch1_class;
    wire [13:0] ch2_class;
    wire [13:0] ch3_class;
    wire [13:0] ch1_curr;
    wire [13:0] ch2_curr;
    wire [13:0] ch3_curr;
    wire [13:0] ch1_volt;
    wire [13:0] ch2_volt;
    wire [13:0] ch3_volt;

    // Per channel result registers
    wire [13:0] ch1_curr_res;
    wire [13:0] ch2_curr_res;
    wire [13:0] ch3_curr_res;
    wire [13:0] ch1_volt_res;
    wire [13:0] ch2_volt_res;
    wire [13:0] ch3_volt_res;

    // Sized end count, so the compare neither pads nor drops bits
    assign tick = (div_q == `CTR_REFRESH_LAST);

    // Roughly 100 ms between refresh ticks; the phase runs from reset,
    // so a port reading may wait anywhere up to one period for release
    always @(posedge mclk or negedge resetn) begin
        if (!resetn)
            div_q <= 22'h000000;
        else if (tick)
            div_q <= 22'h000000;
        else
            div_q <= div_q + 22'h000001;
    end

    // ****************************************
    // Channels
    // ****************************************
    // ****************************************
    // Packed bus split
    // ****************************************

    // Channel 1 sits in the low bits of every packed bus
    assign ch1_class = class_count[13:0];
    assign ch2_class = class_count[27:14];
    assign ch3_class = class_count[41:28];
    assign ch1_curr  = curr_count[13:0];
    assign ch2_curr  = curr_count[27:14];
    assign ch3_curr  = curr_count[41:28];
    assign ch1_volt  = volt_count[13:0];
    assign ch2_volt  = volt_count[27:14];
    assign ch3_volt  = volt_count[41:28];

    // Channel 1
    ctr_channel u_ch1 (
        .mclk         (mclk),
        .resetn       (resetn),
        .refresh_en   (tick),
        .powered      (powered[0]),
        .port_enabled (port_enabled[0]),
        .class_done   (class_done[0]),
        .class_count  (ch1_class),
        .curr_done    (curr_done[0]),
        .curr_count   (ch1_curr),
        .volt_done    (volt_done[0]),
        .volt_count   (ch1_volt),
        .curr_result  (ch1_curr_res),
        .volt_result  (ch1_volt_res),
        .class_scale  (class_scale[0]),
        .overcurrent  (oc[0])
    );

    // Channel 2
    ctr_channel u_ch2 (
        .mclk         (mclk),
        .resetn       (resetn),
        .refresh_en   (tick),
        .powered      (powered[1]),
        .port_enabled (port_enabled[1]),
        .class_done   (class_done[1]),
        .class_count  (ch2_class),
        .curr_done    (curr_done[1]),
        .curr_count   (ch2_curr),
        .volt_done    (volt_done[1]),
        .volt_count   (ch2_volt),
        .curr_result  (ch2_curr_res),
        .volt_result  (ch2_volt_res),
        .class_scale  (class_scale[1]),
        .overcurrent  (oc[1])
    );

    // Channel 3
    ctr_channel u_ch3 (
        .mclk         (mclk),
        .resetn       (resetn),
        .refresh_en   (tick),
        .powered      (powered[2]),
        .port_enabled (port_enabled[2]),
        .class_done   (class_done[2]),
        .class_count  (ch3_class),
        .curr_done    (curr_done[2]),
        .curr_count   (ch3_curr),
        .volt_done    (volt_done[2]),
        .volt_count   (ch3_volt),
        .curr_result  (ch3_curr_res),
        .volt_result  (ch3_volt_res),
        .class_scale  (class_scale[2]),
        .overcurrent  (oc[2])
    );

    // Foldback disable latches until the port is disabled;
    // a disable wins over a same-cycle trip, as the port is off anyway
    always @(posedge mclk or negedge resetn) begin
        if (!resetn)
            fold_disable <= 3'h0;
        else
            fold_disable <= (fold_disable | oc) & port_enabled;
    end

    // ****************************************
    // Command decode and two-byte read
    // ****************************************
    reg  [7:0]  cmd_q;
    reg         byte_q;     // 0: low byte next, 1: high byte next
    reg  [13:0] snap_q;     // High byte comes from the same snapshot
    reg  [13:0] sel;
    reg         hit;

    // Register select; unmapped codes answer with an error and a zero byte.
    // Current words stay mapped so a class reading can be read back.
    always @* begin
        hit = 1'b1;
        sel = `CTR_RES_RESET;
        case (cmd_q)
            `CTR_CMD_CH1_CURR: sel = ch1_curr_res;
            `CTR_CMD_CH1_VOLT: sel = ch1_volt_res;
            `CTR_CMD_CH2_CURR: sel = ch2_curr_res;
            `CTR_CMD_CH2_VOLT: sel = ch2_volt_res;
            `CTR_CMD_CH3_CURR: sel = ch3_curr_res;
            `CTR_CMD_CH3_VOLT: sel = ch3_volt_res;
            default:           hit = 1'b0;
        endcase
    end

    // Low byte first, then high byte; a third read restarts the pair.
    // The high byte comes from the snapshot taken with the low byte, so a
    // conversion landing between the two reads cannot tear the word.
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            cmd_q    <= 8'h00;
            byte_q   <= 1'b0;
            snap_q   <= `CTR_RES_RESET;
            rd_data  <= 8'h00;
            rd_valid <= 1'b0;
            rd_err   <= 1'b0;
        end else begin
            rd_valid <= 1'b0;
            rd_err   <= 1'b0;
            if (cmd_valid) begin
                cmd_q  <= cmd_code;
                byte_q <= 1'b0;
            end else if (rd_req) begin
                rd_valid <= 1'b1;
                rd_err   <= ~hit;
                if (!hit) begin
                    rd_data <= 8'h00;
                end else if (!byte_q) begin
                    snap_q  <= sel;
                    rd_data <= sel[`CTR_LO_MSB:0];
                    byte_q  <= 1'b1;
                end else begin
                    rd_data <= {2'b00, snap_q[`CTR_HI_MSB:`CTR_HI_LSB]};
                    byte_q  <= 1'b0;
                end
            end
        end
    end

endmodule // ctr_readout

// *** sim/ctr_host.sv ***
`timescale 1ns/1ps
// Host side: command byte then two read strobes, low byte first
module ctr_host (
    input  logic       mclk,      // System clock
    output logic       cmd_valid, // Command strobe
    output logic [7:0] cmd_code,  // Command code
    output logic       rd_req,    // Byte read strobe
    input  logic [7:0] rd_data,   // Read byte
    input  logic       rd_valid,  // Byte valid
    input  logic       rd_err     // Unmapped command
);
    initial begin
        cmd_valid = 0;
        cmd_code  = 8'h00;
        rd_req    = 0;
    end
    // Both bytes in one burst so they come from one snapshot; a missing valid turns the byte to x
    task rd16(input logic [7:0] c, output logic [15:0] w, output logic e);
        @(posedge mclk) #1;
        cmd_valid = 1;
        cmd_code  = c;
        @(posedge mclk) #1;
        cmd_valid = 0;
        cmd_code  = ~c;  // Code is meaningless now, so it must not look held
        rd_req    = 1;
        @(posedge mclk) #1;
        w[7:0] = rd_valid ? rd_data : 8'hXX;
        e      = rd_err;
        @(posedge mclk) #1;
        w[15:8] = rd_valid ? rd_data : 8'hXX;
        e       = e | rd_err;
        rd_req  = 0;
    endtask
endmodule // ctr_host

// *** sim/ctr_readout_chk.sv ***
`timescale 1ns/1ps
module ctr_readout_chk (
    input logic mclk, resetn, cmd_valid, rd_req, rd_valid, rd_err,
    input logic [7:0] cmd_code, rd_data,
    input logic [2:0] powered, port_enabled, class_done, curr_done, class_scale, fold_disable,
    input logic [41:0] curr_count
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    rd_lat_a: assert property (rd_req && !cmd_valid |=> rd_valid) else $error("read not answered");
    no_spur_a: assert property (!(rd_req && !cmd_valid) |=> !rd_valid) else $error("stray byte");
    err_zero_a: assert property (rd_err |-> rd_valid && rd_data == 8'h00) else $error("bad error byte");
    data_hold_a: assert property (!rd_valid |-> $stable(rd_data)) else $error("data moved");
    hi_pad_a:
        assert property (cmd_valid && cmd_code[7:4] == 4'h3 ##1 (rd_req && !cmd_valid)[*2] |=> rd_data[7:6] == 2'b00)
        else $error("high byte pad set");
    class_flag_a: assert property (class_done[0] && port_enabled[0] |=> class_scale[0]) else $error("no class");
    class_cause_a: assert property ($rose(class_scale[0]) |-> $past(class_done[0])) else $error("class flag");
    fold_trip_a:
        assert property (curr_done[1] && port_enabled[1] && powered[1] && curr_count[27:14] > 14'h3652
            ##1 port_enabled[1] |=> fold_disable[1])
        else $error("no foldback");
    fold_clear_a: assert property (!port_enabled[1] |=> !fold_disable[1]) else $error("fold held");
endmodule // ctr_readout_chk
bind ctr_readout ctr_readout_chk u_chk (.mclk, .resetn, .cmd_valid, .rd_req, .rd_valid, .rd_err, .cmd_code,
    .rd_data, .powered, .port_enabled, .class_done, .curr_done, .class_scale, .fold_disable, .curr_count);

// *** sim/ctr_readout_tb_top.sv ***
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin n_fail++; \
    $display("Error %s expected %h seen %h", n, e, g); end end
module ctr_readout_tb_top;
    typedef struct {logic [7:0] c; logic [15:0] x; logic er;} ctr_row_t;
    logic mclk = 0, resetn = 0, cmd_valid, rd_req, rd_valid, rd_err, e;
    logic [7:0] cmd_code, rd_data;
    logic [2:0] powered = 0, port_enabled = 0, class_done = 0, curr_done = 0, volt_done = 0;
    logic [2:0] class_scale, fold_disable;
    logic [41:0] class_count = 0, curr_count = 0, volt_count = 0;
    logic [15:0] w;
    int n_fail = 0, checks_done = 0, cyc = 0;
    // Voltage and class words per command, then one unmapped code
    ctr_row_t rows[7] = '{'{8'h32, 16'h3FFF, 0}, '{8'h36, 16'h1234, 0}, '{8'h3A, 16'h2A5C, 0},
        '{8'h30, 16'h0155, 0}, '{8'h34, 16'h2AAA, 0}, '{8'h38, 16'h0001, 0}, '{8'h40, 16'h0000, 1}};
    ctr_readout dut (.mclk, .resetn, .cmd_valid, .cmd_code, .rd_req, .rd_data, .rd_valid, .rd_err, .powered,
        .port_enabled, .class_done, .class_count, .curr_done, .curr_count, .volt_done, .volt_count,
        .class_scale, .fold_disable);
    ctr_host host (.mclk, .cmd_valid, .cmd_code, .rd_req, .rd_data, .rd_valid, .rd_err);
    initial begin
        forever #20 mclk = ~mclk;
    end
    // Hang guard, well above the fifty-odd cycles the run needs
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 5000) begin
            n_fail++;
            end_of_test;
        end
    end
    task end_of_test;
        $display("checks_done %0d n_fail %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge mclk);
        #1 resetn = 1;
        host.rd16(8'h32, w, e);
        `CHK("reset word", 16'h0000, w)
        @(posedge mclk) #1;
        {powered, port_enabled, volt_done, class_done} = 12'hFFF;
        volt_count  = {14'h2A5C, 14'h1234, 14'h3FFF};
        class_count = {14'h0001, 14'h2AAA, 14'h0155};
        @(posedge mclk) #1;
        {volt_done, class_done} = 6'h00;
        @(posedge mclk) #1;
        `CHK("class scale", 3'b111, class_scale)
        foreach (rows[i]) begin
            host.rd16(rows[i].c, w, e);
            `CHK("read word", rows[i].x, w)
            `CHK("read err", rows[i].er, e)
        end
        // One count over the limit trips, the limit itself does not
        curr_count = {14'h3652, 14'h3653, 14'h0000};
        curr_done  = 3'b110;
        @(posedge mclk) #1;
        curr_done = 3'b000;
        @(posedge mclk) #1;
        `CHK("fold", 3'b010, fold_disable)
        `CHK("refresh paced", 3'b111, class_scale)
        host.rd16(8'h38, w, e);
        `CHK("class kept", 16'h0001, w)
        port_enabled = 3'b100;
        repeat (2) @(posedge mclk);
        #1;
        `CHK("fold cleared", 3'b000, fold_disable)
        host.rd16(8'h30, w, e);
        `CHK("disabled current", 16'h0000, w)
        // Mid-run reset clears the held class flag and every result word
        resetn = 0;
        @(posedge mclk) #1;
        `CHK("reset flags", 6'h00, {class_scale, fold_disable})
        resetn = 1;
        host.rd16(8'h3A, w, e);
        `CHK("reset volt", 16'h0000, w)
        end_of_test;
    end
endmodule // ctr_readout_tb_top
